// *** core/fei_pkg.sv ***
// Package of the feature engine init loader: offsets, fields, reset values,
// timing constants, states and carrier types.
// Assumes a 100 MHz core clock.
package fei_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned SENSOR_TICK_NS  = 39250;
  localparam int unsigned SENSOR_TICK_CYC = SENSOR_TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned WR_GAP_US       = 1000;
  localparam int unsigned WR_GAP_CYC      = (WR_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned READY_MAX_MS    = 140;
  localparam int unsigned READY_CYC       = (READY_MAX_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PWR_CONF    = 8'h00;
  localparam logic [7:0] OFS_INIT_CTRL   = 8'h04;
  localparam logic [7:0] OFS_CFG_ADDR    = 8'h08;
  localparam logic [7:0] OFS_CFG_DATA    = 8'h0c;
  localparam logic [7:0] OFS_INT_STATUS  = 8'h10;
  localparam logic [7:0] OFS_SENSOR_TIME = 8'h14;
  localparam logic [7:0] OFS_STATUS      = 8'h18;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int unsigned APS_BIT         = 0;
  localparam int unsigned ST_SUSPEND_BIT  = 0;
  localparam int unsigned ST_CFGMODE_BIT  = 1;
  localparam int unsigned ST_FEAT_BIT     = 2;
  localparam int unsigned ST_ERR_GAP_BIT  = 3;
  localparam int unsigned ST_ERR_DUP_BIT  = 4;
  localparam int unsigned ST_ERR_LOAD_BIT = 5;
  localparam logic        APS_RST         = 1'b1;
  localparam logic [7:0]  INIT_CTRL_RST   = 8'h00;
  localparam logic [7:0]  INIT_CMD_LOAD   = 8'h00;
  localparam logic [7:0]  INIT_CMD_START  = 8'h01;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    MSG_NOT_INIT = 8'h00,
    MSG_INIT_OK  = 8'h01
  } fei_msg_t;

  typedef enum logic [1:0] {
    ENG_LOAD  = 2'b00,
    ENG_BOOT  = 2'b01,
    ENG_READY = 2'b10
  } fei_eng_t;

  typedef struct packed {
    logic acc_suspend;
    logic config_mode;
    logic features_en;
  } fei_status_t;

endpackage : fei_pkg

// *** core/fei_time_base.sv ***
// Free-running sensor time counter with its step prescaler.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fei_time_base #(
  parameter int unsigned TICK_CYC = 3925,
  parameter int unsigned TIME_W   = 24
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Time output
  output logic                   tick_o,
  output logic [TIME_W-1:0]      time_o
);
  import fei_pkg::*;

  localparam int unsigned PW = $clog2(TICK_CYC);

  logic [PW-1:0]     pre_q,  pre_d;
  logic [TIME_W-1:0] time_q, time_d;

  always_comb begin
    tick_o = (pre_q == PW'(TICK_CYC - 1));
    pre_d  = tick_o ? '0 : pre_q + PW'(1);
    time_d = tick_o ? time_q + TIME_W'(1) : time_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q  <= '0;
      time_q <= '0;
    end else begin
      pre_q  <= pre_d;
      time_q <= time_d;
    end
  end

  assign time_o = time_q;

  property p_time_step;
    @(posedge clk_i) disable iff (rst_i)
    tick_o |=> (time_q == $past(time_q) + TIME_W'(1)) ##1 (time_q == $past(time_q));
  endproperty
  a_time_step: assert property (p_time_step) else $error("sensor time step wrong");

  property p_tick_spacing;
    @(posedge clk_i) disable iff (rst_i)
    tick_o |=> !tick_o;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick too frequent");

endmodule : fei_time_base
`default_nettype wire

// *** core/fei_init_loader.sv ***
// Feature engine init loader: AHB-Lite register slave, config image port,
// engine start sequencing, sensor time and supply-driven reset.
// Assumes one AHB-Lite master, hready_i fed back from hreadyout_o.
// Contract
// - Accelerometer suspended, features off until init
// - Sensor time steps every 39.25 us
// - Image readback returns loaded contents
// - Ready message within 140 ms of enable
// - After init, device in configuration mode if power save (aps) is off
// - Either supply low resets the device
// - Power save needs 1000 us between writes
`timescale 1ns/1ps
`default_nettype none
module fei_init_loader #(
  parameter int unsigned CFG_DEPTH   = 256,
  parameter int unsigned TIME_W      = 24,
  parameter int unsigned WR_GAP_CYC  = fei_pkg::WR_GAP_CYC,
  parameter int unsigned READY_CYC   = fei_pkg::READY_CYC
) (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Supply monitors
  input  wire logic                 vdd_ok_i,
  input  wire logic                 vddio_ok_i,
  // AHB-Lite slave
  input  wire logic                 hsel_i,
  input  wire logic [31:0]          haddr_i,
  input  wire logic [1:0]           htrans_i,
  input  wire logic                 hwrite_i,
  input  wire logic [2:0]           hsize_i,
  input  wire logic [31:0]          hwdata_i,
  input  wire logic                 hready_i,
  output logic                      hreadyout_o,
  output logic                      hresp_o,
  output logic [31:0]               hrdata_o,
  // Engine state
  output fei_pkg::fei_status_t      status_o
);
  import fei_pkg::*;

  localparam int unsigned AW = $clog2(CFG_DEPTH);
  localparam int unsigned GW = $clog2(WR_GAP_CYC + 1);
  localparam int unsigned BW = $clog2(READY_CYC + 1);

  // ----------------------------------------------------------------
  // Reset and sensor time
  // ----------------------------------------------------------------
  logic              core_rst;
  logic [TIME_W-1:0] sensor_time;

  assign core_rst = rst_i | ~vdd_ok_i | ~vddio_ok_i;

  fei_time_base #(
    .TICK_CYC (SENSOR_TICK_CYC),
    .TIME_W   (TIME_W)
  ) u_time (
    .clk_i  (clk_i),
    .rst_i  (core_rst),
    .tick_o (),
    .time_o (sensor_time)
  );

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  logic        wr_pend_q, wr_pend_d;
  logic [7:0]  wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q,   rdata_d;
  logic        addr_take, wr_take, rd_take, wr_ok, gap_block;
  logic [31:0] rd_val;
  logic [31:0] cfg_rd_word;

  // Engine and control state
  fei_eng_t    eng_q,       eng_d;
  logic [BW-1:0] boot_cnt_q, boot_cnt_d;
  logic [GW-1:0] gap_cnt_q,  gap_cnt_d;
  logic        aps_q,       aps_d;
  logic [7:0]  init_ctrl_q, init_ctrl_d;
  logic        load_open_q, load_open_d;
  logic [AW-1:0] ptr_q,     ptr_d;
  logic        err_gap_q,   err_gap_d;
  logic        err_dup_q,   err_dup_d;
  logic        err_load_q,  err_load_d;
  fei_msg_t    msg;
  logic        mem_we;
  logic [31:0] cfg_mem [CFG_DEPTH];

  assign addr_take   = hsel_i & hready_i & htrans_i[1] & ~wr_pend_q;
  assign wr_take     = addr_take & hwrite_i;
  assign rd_take     = addr_take & ~hwrite_i;
  assign gap_block   = aps_q & (gap_cnt_q != '0);
  assign wr_ok       = wr_pend_q & ~gap_block;
  assign hreadyout_o = ~wr_pend_q;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_q;
  assign cfg_rd_word = cfg_mem[ptr_q];
  assign msg         = (eng_q == ENG_READY) ? MSG_INIT_OK : MSG_NOT_INIT;

  always_comb begin
    rd_val = 32'h0000_0000;
    unique case (haddr_i[7:0])
      OFS_PWR_CONF:    rd_val[APS_BIT] = aps_q;
      OFS_INIT_CTRL:   rd_val[7:0] = init_ctrl_q;
      OFS_CFG_ADDR:    rd_val[AW-1:0] = ptr_q;
      OFS_CFG_DATA:    rd_val = cfg_rd_word;
      OFS_INT_STATUS:  rd_val[7:0] = msg;
      OFS_SENSOR_TIME: rd_val[TIME_W-1:0] = sensor_time;
      OFS_STATUS: begin
        rd_val[ST_SUSPEND_BIT]  = status_o.acc_suspend;
        rd_val[ST_CFGMODE_BIT]  = status_o.config_mode;
        rd_val[ST_FEAT_BIT]     = status_o.features_en;
        rd_val[ST_ERR_GAP_BIT]  = err_gap_q;
        rd_val[ST_ERR_DUP_BIT]  = err_dup_q;
        rd_val[ST_ERR_LOAD_BIT] = err_load_q;
      end
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  always_comb begin
    wr_pend_d = wr_take;
    wr_addr_d = wr_take ? haddr_i[7:0] : wr_addr_q;
    rdata_d   = rd_take ? rd_val : rdata_q;
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q   <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Control, image port and engine sequencing
  // ----------------------------------------------------------------
  always_comb begin
    eng_d       = eng_q;
    boot_cnt_d  = boot_cnt_q;
    aps_d       = aps_q;
    init_ctrl_d = init_ctrl_q;
    load_open_d = load_open_q;
    ptr_d       = ptr_q;
    mem_we      = 1'b0;
    gap_cnt_d   = (gap_cnt_q != '0) ? gap_cnt_q - GW'(1) : gap_cnt_q;
    err_gap_d   = err_gap_q | (wr_pend_q & gap_block);
    err_dup_d   = err_dup_q;
    err_load_d  = err_load_q;
    if (wr_ok && aps_q) begin
      gap_cnt_d = GW'(WR_GAP_CYC - 1);
    end
    if (rd_take && haddr_i[7:0] == OFS_CFG_DATA) begin
      ptr_d = ptr_q + AW'(1);
    end
    if (wr_ok) begin
      unique case (wr_addr_q)
        OFS_PWR_CONF: aps_d = hwdata_i[APS_BIT];
        OFS_INIT_CTRL: begin
          init_ctrl_d = hwdata_i[7:0];
          if (hwdata_i[7:0] == INIT_CMD_LOAD && eng_q == ENG_LOAD) begin
            load_open_d = 1'b1;
          end else if (hwdata_i[7:0] == INIT_CMD_START) begin
            if (eng_q == ENG_LOAD && load_open_q) begin
              eng_d       = ENG_BOOT;
              boot_cnt_d  = BW'(READY_CYC);
              load_open_d = 1'b0;
            end else begin
              err_dup_d = 1'b1;
            end
          end
        end
        OFS_CFG_ADDR: ptr_d = hwdata_i[AW-1:0];
        OFS_CFG_DATA: begin
          if (load_open_q) begin
            mem_we = 1'b1;
            ptr_d  = ptr_q + AW'(1);
          end else begin
            err_load_d = 1'b1;
          end
        end
        OFS_STATUS: begin
          err_gap_d  = (err_gap_q & ~hwdata_i[ST_ERR_GAP_BIT]) | (wr_pend_q & gap_block);
          err_dup_d  = err_dup_q & ~hwdata_i[ST_ERR_DUP_BIT];
          err_load_d = err_load_q & ~hwdata_i[ST_ERR_LOAD_BIT];
        end
        default: ;
      endcase
    end
    if (eng_q == ENG_BOOT) begin
      boot_cnt_d = boot_cnt_q - BW'(1);
      if (boot_cnt_q == BW'(1)) begin
        eng_d = ENG_READY;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      eng_q       <= ENG_LOAD;
      boot_cnt_q  <= '0;
      gap_cnt_q   <= '0;
      aps_q       <= APS_RST;
      init_ctrl_q <= INIT_CTRL_RST;
      load_open_q <= 1'b0;
      ptr_q       <= '0;
      err_gap_q   <= 1'b0;
      err_dup_q   <= 1'b0;
      err_load_q  <= 1'b0;
    end else begin
      eng_q       <= eng_d;
      boot_cnt_q  <= boot_cnt_d;
      gap_cnt_q   <= gap_cnt_d;
      aps_q       <= aps_d;
      init_ctrl_q <= init_ctrl_d;
      load_open_q <= load_open_d;
      ptr_q       <= ptr_d;
      err_gap_q   <= err_gap_d;
      err_dup_q   <= err_dup_d;
      err_load_q  <= err_load_d;
    end
  end

  // Image store keeps its contents through reset
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      cfg_mem[ptr_q] <= hwdata_i;
    end
  end

  always_comb begin
    status_o.acc_suspend = (eng_q != ENG_READY);
    status_o.features_en = (eng_q == ENG_READY);
    status_o.config_mode = (eng_q == ENG_READY) & ~aps_q;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_suspend;
    @(posedge clk_i) disable iff (core_rst)
    $rose(status_o.features_en) |-> $past(eng_q == ENG_BOOT) && !status_o.acc_suspend;
  endproperty
  a_suspend: assert property (p_suspend) else $error("features on before init");

  property p_msg_not_ready;
    @(posedge clk_i) disable iff (core_rst)
    $rose(msg == MSG_INIT_OK) |-> $past(eng_q == ENG_BOOT) && $past(boot_cnt_q == BW'(1));
  endproperty
  a_msg_not_ready: assert property (p_msg_not_ready) else $error("ready message too early");

  property p_ready_time;
    @(posedge clk_i) disable iff (core_rst)
    (eng_q == ENG_BOOT && boot_cnt_q == BW'(1)) |=> (eng_q == ENG_READY) && (msg == MSG_INIT_OK);
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("ready not reached on time");

  property p_boot_bound;
    @(posedge clk_i) disable iff (core_rst)
    (eng_q == ENG_BOOT) |-> (boot_cnt_q <= BW'(READY_CYC)) && (boot_cnt_q != '0);
  endproperty
  a_boot_bound: assert property (p_boot_bound) else $error("boot count out of range");

  property p_cfg_mode;
    @(posedge clk_i) disable iff (core_rst)
    $rose(eng_q == ENG_READY) |-> status_o.config_mode;
  endproperty
  a_cfg_mode: assert property (p_cfg_mode) else $error("not in config mode after init");

  property p_gap;
    @(posedge clk_i) disable iff (core_rst)
    (wr_pend_q && gap_block) |=> err_gap_q && $stable(aps_q) && $stable(init_ctrl_q);
  endproperty
  a_gap: assert property (p_gap) else $error("write inside power save gap taken");

  property p_supply;
    @(posedge clk_i)
    (!vdd_ok_i || !vddio_ok_i) |=> (eng_q == ENG_LOAD) && aps_q && !load_open_q;
  endproperty
  a_supply: assert property (p_supply) else $error("supply drop did not reset");

  property p_single_start;
    @(posedge clk_i) disable iff (core_rst)
    (wr_ok && wr_addr_q == OFS_INIT_CTRL && hwdata_i[7:0] == INIT_CMD_START && eng_q != ENG_LOAD)
      |=> err_dup_q && (eng_q == $past(eng_q));
  endproperty
  a_single_start: assert property (p_single_start) else $error("second enable restarted engine");

  property p_readback;
    @(posedge clk_i) disable iff (core_rst)
    (rd_take && haddr_i[7:0] == OFS_CFG_DATA) |=> (hrdata_o == $past(cfg_rd_word)) && hreadyout_o;
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");

  property p_load_step;
    @(posedge clk_i) disable iff (core_rst)
    (wr_ok && wr_addr_q == OFS_CFG_DATA && load_open_q) |=> (ptr_q == $past(ptr_q) + AW'(1));
  endproperty
  a_load_step: assert property (p_load_step) else $error("image pointer did not advance");

endmodule : fei_init_loader
`default_nettype wire

// *** testbench/fei_host_model.sv ***
// Host processor model: AHB-Lite master doing single word transfers.
// Assumes hready_i is the slave's hreadyout and one slave on the bus.
`timescale 1ns/1ps
`default_nettype none
module fei_host_model (
  // Clock
  input  wire logic        clk_i,
  // Bus answer
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  // Bus request
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o
);
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0;
  end

  // ----------------------------------------------------------------
  // Transfers
  // ----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel_o   <= 1'b1;
    haddr_o  <= {24'h0, a};
    htrans_o <= 2'b10;
    hwrite_o <= w;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    htrans_o <= 2'b00;
    hwdata_o <= wd;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    rd = hrdata_i;
    // Stale data flips once released
    hwdata_o <= ~wd;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, ~hwdata_o, d);
  endtask : rd
endmodule : fei_host_model
`default_nettype wire

// *** testbench/tb_fei_init_loader.sv ***
// Self-checking bench of the init loader: host model drives the bus.
// Assumes shortened gap and ready counts set at the instance.
`timescale 1ns/1ps
`default_nettype none
module tb_fei_init_loader;
  import fei_pkg::*;
  localparam int unsigned GAP   = 20;
  localparam int unsigned RDY   = 50;
  localparam int unsigned LIMIT = 98000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        vdd = 1'b1;
  logic        vddio = 1'b1;
  logic        hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, t0, t1;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  fei_status_t status;
  logic [31:0] img [12];
  logic [31:0] seed = 32'd12;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          n;

  fei_init_loader #(.CFG_DEPTH(256), .TIME_W(24), .WR_GAP_CYC(GAP), .READY_CYC(RDY)) i_fei_init_loader (
    .clk_i(clk), .rst_i(rst), .vdd_ok_i(vdd), .vddio_ok_i(vddio), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .status_o(status));

  fei_host_model i_fei_host_model (
    .clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  function automatic logic [31:0] stat(input logic s, c, f, g, d, l);
    return {26'h0, l, d, g, f, c, s};
  endfunction : stat

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    i_fei_host_model.rd(a, d);
    chk(what, d, exp);
  endtask : rchk

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  always #5 clk = ~clk;

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_total++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("status_o reset", {29'h0, status}, 32'h4);
    rchk(OFS_INT_STATUS, {24'h0, MSG_NOT_INIT}, "int_status reset");
    rchk(OFS_PWR_CONF, 32'h1, "pwr_conf reset");
    i_fei_host_model.wr(OFS_CFG_ADDR, 32'h5);
    i_fei_host_model.wr(OFS_CFG_ADDR, 32'h7);
    rchk(OFS_CFG_ADDR, 32'h5, "write too soon");
    repeat (GAP) @(posedge clk);
    i_fei_host_model.wr(OFS_PWR_CONF, 32'h0);
    i_fei_host_model.rd(OFS_SENSOR_TIME, t0);
    repeat (SENSOR_TICK_CYC - 2) @(posedge clk);
    i_fei_host_model.rd(OFS_SENSOR_TIME, t1);
    chk("sensor step", t1 - t0, 32'h1);
    repeat (45000) @(posedge clk);
    i_fei_host_model.wr(OFS_CFG_DATA, 32'hdead);
    i_fei_host_model.wr(8'h40, 32'hffffffff);
    rchk(8'h40, 32'h0, "unmapped");
    rchk(OFS_STATUS, stat(1, 0, 0, 1, 0, 1), "err flags");
    i_fei_host_model.wr(OFS_STATUS, 32'h38);
    rchk(OFS_STATUS, stat(1, 0, 0, 0, 0, 0), "err clear");
    i_fei_host_model.wr(OFS_INIT_CTRL, {24'h0, INIT_CMD_LOAD});
    i_fei_host_model.wr(OFS_CFG_ADDR, 32'h0);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      img[i] = seed;
      i_fei_host_model.wr(OFS_CFG_DATA, seed);
      if (i == 5) repeat (seed[3:0]) @(posedge clk);
    end
    rchk(OFS_CFG_ADDR, 32'd12, "pointer after bursts");
    i_fei_host_model.wr(OFS_CFG_ADDR, 32'hff);
    i_fei_host_model.wr(OFS_CFG_DATA, seed);
    rchk(OFS_CFG_ADDR, 32'h0, "pointer wrap");
    for (int i = 0; i < 12; i++) begin
      rchk(OFS_CFG_DATA, img[i], "image readback");
    end
    chk("hresp_o", {31'h0, hresp}, 32'h0);
    i_fei_host_model.wr(OFS_INIT_CTRL, {24'h0, INIT_CMD_START});
    rchk(OFS_INT_STATUS, {24'h0, MSG_NOT_INIT}, "not ready yet");
    n = 2;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (status.features_en !== 1'b1 && n < 4 * RDY);
    chk("ready delay", n, RDY - 1);
    chk("status_o ready", {29'h0, status}, 32'h3);
    @(posedge clk);
    rchk(OFS_INT_STATUS, {24'h0, MSG_INIT_OK}, "int_status ready");
    i_fei_host_model.wr(OFS_INIT_CTRL, {24'h0, INIT_CMD_START});
    rchk(OFS_STATUS, stat(0, 1, 1, 0, 1, 0), "repeat enable");
    for (int k = 0; k < 2; k++) begin
      if (k == 0) vdd <= 1'b0;
      else vddio <= 1'b0;
      @(posedge clk);
      vdd <= 1'b1;
      vddio <= 1'b1;
      @(posedge clk);
      #1;
      chk("status_o supply", {29'h0, status}, 32'h4);
      @(posedge clk);
      rchk(OFS_INT_STATUS, {24'h0, MSG_NOT_INIT}, "int_status supply");
    end
    // Full init again after the supply reset
    i_fei_host_model.wr(OFS_PWR_CONF, 32'h0);
    repeat (45000) @(posedge clk);
    i_fei_host_model.wr(OFS_INIT_CTRL, {24'h0, INIT_CMD_LOAD});
    i_fei_host_model.wr(OFS_CFG_ADDR, 32'h0);
    i_fei_host_model.wr(OFS_CFG_DATA, img[0]);
    i_fei_host_model.wr(OFS_INIT_CTRL, {24'h0, INIT_CMD_START});
    repeat (RDY) @(posedge clk);
    rchk(OFS_STATUS, stat(0, 1, 1, 0, 0, 0), "second init");
    print_verdict();
  end
endmodule : tb_fei_init_loader
`default_nettype wire
